// *** src/usb_host_state_control.v ***
/*
  Operating mode control, version and resume/frame-start status registers
  of an embedded USB host controller, reached by read and write command codes.
  Assumes the command port is driven by same-clock bus logic, and that the
  downstream resume indication comes from another domain.
*/
// Functional notes
// - Version register returns BCD interface version in bits 7..0, zeros above.
// - Remote wake-up enable bit 10 changes only through driver writes and either reset, which clears it.
// - Enable set together with resume-seen flag raises remote wake-up to host.
// - Remote wake-up enable never affects interrupt generation.
// - Wake-up connected bit 9 cleared by hardware reset, kept on software reset.
// - State field bits 7..6: reset, resume, running, suspended; both resets force reset.
// - Entering running state starts frame-start packets 1 ms plus one clock later.
// - Hardware changes state field only while it holds suspended.
// - Resume from downstream port while suspended moves state to resume.
// - Hardware reset also resets root hub and drives port reset; software reset not.
// - Resume while suspended sets resume-seen flag, read 03H, cleared by write 83H.
`timescale 1ns/100ps
`include "usb_host_state_control_consts.vh"

module usb_host_state_control #(
  parameter SOF_DELAY_CYCLES = `SOF_DELAY_NS / `CLK_PERIOD_NS,
  parameter [7:0] VERSION_CODE = 8'h2_5  // Arbitrary value
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        soft_rst,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_code,
  input  wire [31:0] cmd_wdata,
  output reg  [31:0] cmd_rdata,
  output reg         cmd_rvalid,
  input  wire        port_resume_in,
  output wire [1:0]  functional_state,
  output wire        frame_gen_active,
  output wire        remote_wakeup_req,
  output wire        root_hub_reset
);

  // ==========================================================
  // Input synchroniser
  reg resume_meta_q;
  reg resume_sync_q;
  always @(posedge core_clk) begin
    resume_meta_q <= port_resume_in;
    resume_sync_q <= resume_meta_q;
  end

  // ==========================================================
  // Command decode
  // Read commands carry a clear direction bit
  function is_read;
    input       valid;
    input [7:0] code;
    begin
      is_read = valid && !code[`CMD_DIR_BIT];
    end
  endfunction

  wire rd_cmd     = is_read(cmd_valid, cmd_code);
  wire wr_control = cmd_valid && (cmd_code == `CMD_WR_CONTROL);
  wire wr_status  = cmd_valid && (cmd_code == `CMD_WR_INT_STATUS);

  // ==========================================================
  // Control register
  reg  [1:0]  state_q;
  reg         rwe_q;
  reg         rwc_q;
  reg         hub_reset_q;
  wire        resume_evt = (state_q == `FS_SUSPENDED) && resume_sync_q;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_q     <= `FS_BUS_RESET;
      rwe_q       <= 1'b0;
      rwc_q       <= 1'b0;
      hub_reset_q <= 1'b1;
    end else if (soft_rst) begin
      state_q     <= `FS_BUS_RESET;
      rwe_q       <= 1'b0;
    end else begin
      if (wr_control) begin
        state_q <= cmd_wdata[`FS_MSB:`FS_LSB];
        rwe_q   <= cmd_wdata[`RWE_BIT];
        rwc_q   <= cmd_wdata[`RWC_BIT];
      end else if (resume_evt) begin
        state_q <= `FS_BUS_RESUME;
      end
      if (state_q != `FS_BUS_RESET)
        hub_reset_q <= 1'b0;
    end
  end

  // ==========================================================
  // Frame-start delay after entering running state
  reg [31:0] sof_cnt_q;
  reg        sof_on_q;
  reg [1:0]  prev_state_q;
  wire       enter_run = (state_q == `FS_RUNNING) && (prev_state_q != `FS_RUNNING);

  always @(posedge core_clk) begin
    if (sys_rst || soft_rst) begin
      prev_state_q <= `FS_BUS_RESET;
      sof_cnt_q    <= `DATA_ZERO;
      sof_on_q     <= 1'b0;
    end else begin
      prev_state_q <= state_q;
      if (state_q != `FS_RUNNING) begin
        sof_cnt_q <= `DATA_ZERO;
        sof_on_q  <= 1'b0;
      end else if (enter_run) begin
        sof_cnt_q <= 32'h0000_0001;
      end else if (!sof_on_q) begin
        if (sof_cnt_q >= SOF_DELAY_CYCLES[31:0])
          sof_on_q <= 1'b1;
        else
          sof_cnt_q <= sof_cnt_q + 32'h0000_0001;
      end
    end
  end
  wire sof_start = (state_q == `FS_RUNNING) && !enter_run && !sof_on_q &&
                   (sof_cnt_q >= SOF_DELAY_CYCLES[31:0]);

  // ==========================================================
  // Interrupt status flags; set wins over write-one clear
  reg resume_seen_q;
  reg frame_start_q;
  always @(posedge core_clk) begin
    if (sys_rst || soft_rst) begin
      resume_seen_q <= 1'b0;
      frame_start_q <= 1'b0;
    end else begin
      if (resume_evt)
        resume_seen_q <= 1'b1;
      else if (wr_status && cmd_wdata[`RESUME_SEEN_BIT])
        resume_seen_q <= 1'b0;
      if (sof_start)
        frame_start_q <= 1'b1;
      else if (wr_status && cmd_wdata[`FRAME_START_BIT])
        frame_start_q <= 1'b0;
    end
  end

  // ==========================================================
  // Read path, one cycle after the command
  reg [31:0] rd_d;
  always @* begin
    rd_d = `DATA_ZERO;
    case (cmd_code)
      `CMD_RD_VERSION: rd_d[`VERSION_MSB:`VERSION_LSB] = VERSION_CODE;
      `CMD_RD_CONTROL: begin
        rd_d[`FS_MSB:`FS_LSB] = state_q;
        rd_d[`RWC_BIT]        = rwc_q;
        rd_d[`RWE_BIT]        = rwe_q;
      end
      `CMD_RD_INT_STATUS: begin
        rd_d[`RESUME_SEEN_BIT] = resume_seen_q;
        rd_d[`FRAME_START_BIT] = frame_start_q;
      end
      default: rd_d = `DATA_ZERO;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_rdata  <= `DATA_ZERO;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rvalid <= rd_cmd;
      if (rd_cmd)
        cmd_rdata <= rd_d;
    end
  end

  // ==========================================================
  // Outputs; wake-up request feeds no interrupt logic
  assign functional_state  = state_q;
  assign frame_gen_active  = sof_on_q;
  assign remote_wakeup_req = rwe_q && resume_seen_q;
  assign root_hub_reset    = hub_reset_q;

endmodule // usb_host_state_control

// *** src/usb_host_state_control_consts.vh ***
/*
  Constants for the host controller state and identification registers:
  command codes, field positions, reset values and timing figures.
  Assumes it is included by bare name from the design files under src/.
*/
`ifndef USB_HOST_STATE_CONTROL_CONSTS_VH
`define USB_HOST_STATE_CONTROL_CONSTS_VH

// ==========================================================
// Command codes (read / write)
`define CMD_RD_VERSION      8'h00
`define CMD_RD_CONTROL      8'h01
`define CMD_WR_CONTROL      8'h81
`define CMD_RD_INT_STATUS   8'h03
`define CMD_WR_INT_STATUS   8'h83
`define CMD_DIR_BIT         7

// ==========================================================
// Version register
`define VERSION_LSB         0
`define VERSION_MSB         7
`define VERSION_W           8

// ==========================================================
// Control register fields
`define FS_LSB              6
`define FS_MSB              7
`define RWC_BIT             9
`define RWE_BIT             10
`define CONTROL_RESET       32'h0000_0000

// ==========================================================
// Functional state encodings
`define FS_BUS_RESET        2'h0
`define FS_BUS_RESUME       2'h1
`define FS_RUNNING          2'h2
`define FS_SUSPENDED        2'h3

// ==========================================================
// Interrupt status bits
`define FRAME_START_BIT     2
`define RESUME_SEEN_BIT     3

// ==========================================================
// Timing
`define CLK_PERIOD_NS       10
`define SOF_DELAY_NS        1000000
`define DATA_ZERO           32'h0000_0000

`endif

// *** tb/usb_host_state_control_props.sv ***
/* Checker on the ports of usb_host_state_control.
   Assumes a bind from the bench top with the same frame delay. */
`timescale 1ns/100ps
module usb_host_state_control_props #(
  parameter SOF_DELAY_CYCLES = 20
) (
  input wire        core_clk,
  input wire        sys_rst,
  input wire        soft_rst,
  input wire        cmd_valid,
  input wire [7:0]  cmd_code,
  input wire [31:0] cmd_rdata,
  input wire        cmd_rvalid,
  input wire        port_resume_in,
  input wire [1:0]  functional_state,
  input wire        frame_gen_active,
  input wire        remote_wakeup_req,
  input wire        root_hub_reset
);
  // ==========================================
  // Cycles spent in the running state
  reg [31:0] run_q;
  always @(posedge core_clk) begin
    run_q <= (sys_rst || functional_state != 2'h2) ? 32'h0 : run_q + 1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Properties
  rd_version_a: assert property (cmd_valid && cmd_code == 8'h00
    |=> cmd_rvalid && cmd_rdata[31:8] == 24'h0) else $error("version read bad");
  hw_state_a: assert property ($fell(sys_rst)
    |-> functional_state == 2'h0 && root_hub_reset) else $error("hw reset state bad");
  soft_state_a: assert property (soft_rst |=> functional_state == 2'h0
    && !frame_gen_active) else $error("soft reset state bad");
  state_hold_a: assert property (functional_state != 2'h3 && !soft_rst
    && !(cmd_valid && cmd_code == 8'h81) |=> $stable(functional_state))
    else $error("state moved by itself");
  resume_move_a: assert property ((functional_state == 2'h3 && port_resume_in
    && !cmd_valid && !soft_rst)[*3] |=> functional_state == 2'h1) else $error("no resume");
  wake_hold_a: assert property (remote_wakeup_req && !soft_rst
    && !(cmd_valid && cmd_code[7]) |=> remote_wakeup_req) else $error("wake-up dropped");
  sof_delay_a: assert property ($rose(frame_gen_active)
    |-> run_q == SOF_DELAY_CYCLES + 1) else $error("frame start time bad");
  soft_hub_a: assert property (soft_rst && !root_hub_reset
    |=> !root_hub_reset) else $error("soft reset hit root hub");
endmodule // usb_host_state_control_props

// *** tb/host_driver_model.sv ***
/* Driver side of the command port: one command per call, driven
   at the falling edge. Assumes the read answer comes one cycle later. */
`timescale 1ns/100ps
module host_driver_model (
  input  wire        core_clk,
  output reg         cmd_valid = 1'b0,
  output reg  [7:0]  cmd_code = 8'h00,
  output reg  [31:0] cmd_wdata = 32'h0000_0000,
  input  wire [31:0] cmd_rdata,
  input  wire        cmd_rvalid
);
  task xfer(input [7:0] c, input [31:0] d, output [31:0] r);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_wdata = ~d;
    r = (cmd_rvalid || c[7]) ? cmd_rdata : 32'hxxxx_xxxx;
  endtask
  // Read, merge, write back keeping other bits
  task rmw(input [31:0] mask, input [31:0] val);
    reg [31:0] r;
    xfer(8'h01, 32'h0000_0000, r);
    xfer(8'h81, (r & ~mask) | val, r);
  endtask
endmodule // host_driver_model

// *** tb/usb_host_state_control_test.sv ***
/* Self-checking bench for usb_host_state_control.
   Assumes the checker and driver model files are compiled first. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin $display("mismatch %s exp %h got %h", n, e, s); err_count++; end end
module usb_host_state_control_test;
  localparam N = 20;
  localparam [7:0] VER = 8'h25; // Arbitrary
  reg         core_clk = 0, sys_rst = 1, soft_rst = 0, port_resume_in = 0;
  wire        cmd_valid, cmd_rvalid, frame_gen_active, remote_wakeup_req, root_hub_reset;
  wire [7:0]  cmd_code;
  wire [31:0] cmd_wdata, cmd_rdata;
  wire [1:0]  functional_state;
  reg  [31:0] q;
  integer     err_count = 0, n_compared = 0, cyc = 0, k;
  usb_host_state_control #(.SOF_DELAY_CYCLES(N), .VERSION_CODE(VER)) usb_host_state_control_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .port_resume_in(port_resume_in),
    .functional_state(functional_state), .frame_gen_active(frame_gen_active),
    .remote_wakeup_req(remote_wakeup_req), .root_hub_reset(root_hub_reset));
  host_driver_model host_driver_model_i (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      summarize;
    end
  end
  task summarize;
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_modes;
    `CHK("hub", 1'b1, root_hub_reset)
    host_driver_model_i.xfer(8'h00, 32'h0000_0000, q);
    `CHK("version", {24'h0, VER}, q)
    `CHK("rvalid", 1'b1, cmd_rvalid)
    for (k = 0; k < 4; k++) begin
      host_driver_model_i.xfer(8'h81, k << 6, q);
      `CHK("state", k[1:0], functional_state)
      `CHK("wr no rvalid", 1'b0, cmd_rvalid)
    end
    host_driver_model_i.xfer(8'h81, 32'hFFFF_FFFF, q);
    host_driver_model_i.xfer(8'h01, 32'h0000_0000, q);
    `CHK("control", 32'h0000_06C0, q)
  endtask
  task t_resume;
    @(negedge core_clk) port_resume_in = 1;
    repeat (4) @(negedge core_clk);
    `CHK("resume", 2'h1, functional_state)
    `CHK("wake", 1'b1, remote_wakeup_req)
    host_driver_model_i.xfer(8'h03, 32'h0000_0000, q);
    `CHK("status", 32'h0000_0008, q)
    port_resume_in = 0;
    host_driver_model_i.xfer(8'h83, 32'h0000_0008, q);
    `CHK("wake clr", 1'b0, remote_wakeup_req)
  endtask
  task t_sof;
    host_driver_model_i.rmw(32'h0000_00C0, 32'h0000_0080);
    for (k = 0; !frame_gen_active && k < 200; k++) @(negedge core_clk);
    `CHK("sof delay", N + 1, k)
    host_driver_model_i.xfer(8'h03, 32'h0000_0000, q);
    `CHK("sof flag", 32'h0000_0004, q)
  endtask
  task t_resets;
    @(negedge core_clk) soft_rst = 1;
    @(negedge core_clk) soft_rst = 0;
    `CHK("soft state", 2'h0, functional_state)
    `CHK("soft hub", 1'b0, root_hub_reset)
    host_driver_model_i.xfer(8'h01, 32'h0000_0000, q);
    `CHK("soft ctl", 32'h0000_0200, q)
    sys_rst = 1;
    repeat (2) @(negedge core_clk);
    sys_rst = 0;
    host_driver_model_i.xfer(8'h01, 32'h0000_0000, q);
    `CHK("hw ctl", 32'h0000_0000, q)
    `CHK("hw hub", 1'b1, root_hub_reset)
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    sys_rst = 0;
    t_modes;
    t_resume;
    t_sof;
    t_resets;
    summarize;
  end
endmodule // usb_host_state_control_test
bind usb_host_state_control usb_host_state_control_props #(.SOF_DELAY_CYCLES(SOF_DELAY_CYCLES))
  props_i (.core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
  .port_resume_in(port_resume_in), .functional_state(functional_state),
  .frame_gen_active(frame_gen_active), .remote_wakeup_req(remote_wakeup_req),
  .root_hub_reset(root_hub_reset));
